// ### pkg/xtp_pkg.sv
/*
  Constants, state codes and the trap vector table of the trap and
  priority unit: source order, masks, vectors and timing counts.
  Assumes a 10 MHz processor clock and 16-bit addresses and words.
*/
package xtp_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TMO_MIN_US = 5;
  localparam int TMO_CYC = (TMO_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int PF_HOLD_MS = 2;
  localparam int PF_HOLD_CYC = (PF_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;

  // ==========================================================
  // Service order, index 0 is served first
  localparam int NUM_SRC = 27;
  localparam int SRC_W = 5;
  localparam logic [SRC_W-1:0] SRC_CONSOLE = 5'h00;
  localparam logic [SRC_W-1:0] SRC_ODD = 5'h01;
  localparam logic [SRC_W-1:0] SRC_FATAL = 5'h02;
  localparam logic [SRC_W-1:0] SRC_MMUV = 5'h03;
  localparam logic [SRC_W-1:0] SRC_TMO = 5'h04;
  localparam logic [SRC_W-1:0] SRC_PAR = 5'h05;
  localparam logic [SRC_W-1:0] SRC_FPPX = 5'h06;
  localparam logic [SRC_W-1:0] SRC_MMUT = 5'h07;
  localparam logic [SRC_W-1:0] SRC_WARN = 5'h08;
  localparam logic [SRC_W-1:0] SRC_PWR = 5'h09;
  localparam logic [SRC_W-1:0] SRC_RSV = 5'h0a;
  localparam logic [SRC_W-1:0] SRC_TRACE = 5'h0b;
  localparam logic [SRC_W-1:0] SRC_IOT = 5'h0c;
  localparam logic [SRC_W-1:0] SRC_EMT = 5'h0d;
  localparam logic [SRC_W-1:0] SRC_TRAPI = 5'h0e;
  localparam logic [SRC_W-1:0] SRC_FPE = 5'h0f;
  localparam logic [SRC_W-1:0] SRC_SW7 = 5'h10;
  localparam logic [SRC_W-1:0] SRC_BR7 = 5'h11;
  localparam logic [SRC_W-1:0] SRC_BR4 = 5'h17;
  localparam logic [SRC_W-1:0] SRC_SW3 = 5'h18;
  localparam logic [SRC_W-1:0] SRC_SW_TOP = 5'h1b;

  // Sources held in pending flags, and sources that abort the instruction
  localparam logic [NUM_SRC-1:0] EVENT_MASK = 27'h000ffbe;
  localparam logic [NUM_SRC-1:0] ABORT_MASK = 27'h000003e;

  // ==========================================================
  // Vectors, stack and status fields
  localparam logic [15:0] VEC_ERR = 16'h0004;
  localparam logic [15:0] VEC_RSV = 16'h0008;
  localparam logic [15:0] VEC_PWR = 16'h0014;
  localparam logic [15:0] VEC_TRACE = 16'h0060;
  localparam logic [15:0] VEC_IOT = 16'h0064;
  localparam logic [15:0] VEC_EMT = 16'h0068;
  localparam logic [15:0] VEC_TRAPI = 16'h006c;
  localparam logic [15:0] VEC_PAR = 16'h0070;
  localparam logic [15:0] VEC_MMU = 16'h0074;
  localparam logic [15:0] VEC_FPE = 16'h0078;
  localparam logic [15:0] VEC_SW = 16'h007c;
  localparam logic [15:0] FATAL_SP = 16'h0004;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] PAIR_STEP = 16'h0004;
  localparam int PRI_LSB = 5;
  localparam int PRI_MSB = 7;
  localparam int MODE_LSB = 14;
  localparam int MODE_MSB = 15;
  localparam logic [2:0] PRI_TOP = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD_PC = 3'h1,
    ST_RD_PS = 3'h2,
    ST_SEL = 3'h3,
    ST_PUSH_PS = 3'h4,
    ST_PUSH_PC = 3'h5
  } xtp_state_t;

  function automatic logic [15:0] xtp_vector(input logic [SRC_W-1:0] src);
    case (src)
      SRC_ODD, SRC_FATAL, SRC_TMO, SRC_WARN: xtp_vector = VEC_ERR;
      SRC_PWR: xtp_vector = VEC_PWR;
      SRC_RSV: xtp_vector = VEC_RSV;
      SRC_TRACE: xtp_vector = VEC_TRACE;
      SRC_IOT: xtp_vector = VEC_IOT;
      SRC_EMT: xtp_vector = VEC_EMT;
      SRC_TRAPI: xtp_vector = VEC_TRAPI;
      SRC_PAR: xtp_vector = VEC_PAR;
      SRC_MMUV, SRC_MMUT: xtp_vector = VEC_MMU;
      SRC_FPE: xtp_vector = VEC_FPE;
      default: xtp_vector = VEC_SW;
    endcase
  endfunction

endpackage

// ### pkg/xtp_arb_if.sv
/*
  Request and pick signals between the trap unit and its priority picker.
  Assumes the picker is purely combinational.
*/
`timescale 1ns/1ns
interface xtp_arb_if #(parameter int N = xtp_pkg::NUM_SRC);
  logic [N-1:0] req;
  logic any;
  logic [$clog2(N)-1:0] idx;
  modport client(output req, input any, input idx);
  modport picker(input req, output any, output idx);
endinterface

// ### core/xtp_prio_pick.sv
/*
  Fixed priority picker: the lowest set request index wins.
  Assumes the caller orders its requests from most to least urgent.
*/
`timescale 1ns/1ns
module xtp_prio_pick #(
  parameter int N = xtp_pkg::NUM_SRC
) (
  xtp_arb_if.picker arb
);
  localparam int IW = $clog2(N);

  // ==========================================================
  // Scan from the top index down so the most urgent request is written last
  always_comb begin
    arb.any = 1'b0;
    arb.idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (arb.req[i]) begin
        arb.any = 1'b1;
        arb.idx = IW'(i);
      end
    end
  end
endmodule

// ### core/xtp_trap_unit.sv
/*
  Trap and priority unit: catches trap conditions, ranks them with the
  interrupt levels, aborts where needed and runs the vector and stack
  sequence over a simple memory port.
  Assumes the execution core supplies event pulses, the instruction
  boundary, the current counter, status and the selected stack pointer.
*/
`timescale 1ns/1ns
module xtp_trap_unit #(
  parameter int PF_HOLD_CYCLES = xtp_pkg::PF_HOLD_CYC,
  parameter int TIMEOUT_CYCLES = xtp_pkg::TMO_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic console_flag_i,
  input wire logic odd_word_access_i,
  input wire logic stack_fatal_i,
  input wire logic mmu_violation_i,
  input wire logic parity_error_i,
  input wire logic fpp_xfer_req_i,
  input wire logic mmu_trap_i,
  input wire logic stack_warn_i,
  input wire logic power_fail_i,
  input wire logic power_restored_i,
  input wire logic reserved_opcode_i,
  input wire logic trace_trap_i,
  input wire logic io_trap_instruction_i,
  input wire logic emulator_trap_instruction_i,
  input wire logic trap_instruction_i,
  input wire logic fpp_exception_i,
  input wire logic [7:1] software_interrupt_request_level_i,
  input wire logic [7:4] bus_request_level_i,
  input wire logic [15:0] bus_vector_i,
  input wire logic instr_boundary_i,
  input wire logic master_sync_i,
  input wire logic slave_sync_i,
  input wire logic [15:0] program_counter_i,
  input wire logic [15:0] processor_status_word_i,
  input wire logic [15:0] stack_pointer_i,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  output logic abort_o,
  output logic halt_req_o,
  output logic fpp_grant_o,
  output logic [7:4] bus_grant_o,
  output logic [7:1] software_ack_o,
  output logic busy_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  output logic [1:0] stack_mode_o,
  output logic load_o,
  output logic [15:0] program_counter_o,
  output logic [15:0] processor_status_word_o,
  output logic [15:0] stack_pointer_o,
  output logic [15:0] trap_vector_o,
  output logic supply_release_o
);
  import xtp_pkg::*;

  localparam logic [15:0] TMO_LAST = 16'(TIMEOUT_CYCLES - 1);
  localparam logic [31:0] PF_LAST = 32'(PF_HOLD_CYCLES - 1);

  xtp_state_t state_reg, state_next;
  logic [NUM_SRC-1:0] pend_reg, pend_next;
  logic [SRC_W-1:0] src_reg, src_next;
  logic [15:0] vec_reg, vec_next, old_pc_reg, old_pc_next;
  logic [15:0] old_ps_reg, old_ps_next, new_pc_reg, new_pc_next;
  logic [15:0] new_ps_reg, new_ps_next, sp_reg, sp_next;
  logic [15:0] addr_reg, addr_next, wdata_reg, wdata_next;
  logic fatal_reg, fatal_next, req_reg, req_next, we_reg, we_next;
  logic abort_reg, abort_next, halt_reg, halt_next, load_reg, load_next;
  logic fppg_reg, fppg_next, busy_reg, busy_next;
  logic [1:0] mode_reg, mode_next;
  logic [7:4] bgrant_reg, bgrant_next;
  logic [7:1] swack_reg, swack_next;
  logic [15:0] tmo_cnt_reg;
  logic [31:0] pf_cnt_reg;
  logic pf_seen_reg, pf_run_reg, release_reg;

  // ==========================================================
  // Request collection
  xtp_arb_if #(.N(NUM_SRC)) arb ();
  xtp_prio_pick #(.N(NUM_SRC)) u_pick (.arb(arb));

  wire [2:0] cur_pri = processor_status_word_i[PRI_MSB:PRI_LSB];
  wire tmo_wait = master_sync_i && !slave_sync_i;
  wire tmo_fire = tmo_wait && (tmo_cnt_reg == TMO_LAST);
  wire [NUM_SRC-1:0] lvl, ev_set, acc, clr;
  wire [NUM_SRC-1:0] pick_hot = {{(NUM_SRC - 1){1'b0}}, 1'b1} << arb.idx;

  assign ev_set[SRC_CONSOLE] = 1'b0;
  assign ev_set[SRC_ODD] = odd_word_access_i;
  assign ev_set[SRC_FATAL] = stack_fatal_i;
  assign ev_set[SRC_MMUV] = mmu_violation_i;
  assign ev_set[SRC_TMO] = tmo_fire;
  assign ev_set[SRC_PAR] = parity_error_i;
  assign ev_set[SRC_FPPX] = 1'b0;
  assign ev_set[SRC_MMUT] = mmu_trap_i;
  assign ev_set[SRC_WARN] = stack_warn_i;
  assign ev_set[SRC_PWR] = power_fail_i || power_restored_i;
  assign ev_set[SRC_RSV] = reserved_opcode_i;
  assign ev_set[SRC_TRACE] = trace_trap_i;
  assign ev_set[SRC_IOT] = io_trap_instruction_i;
  assign ev_set[SRC_EMT] = emulator_trap_instruction_i;
  assign ev_set[SRC_TRAPI] = trap_instruction_i;
  assign ev_set[SRC_FPE] = fpp_exception_i;
  assign ev_set[NUM_SRC-1:SRC_SW7] = '0;

  assign lvl[SRC_CONSOLE] = console_flag_i;
  assign lvl[SRC_PAR:SRC_ODD] = '0;
  assign lvl[SRC_FPPX] = fpp_xfer_req_i;
  assign lvl[SRC_FPE:SRC_MMUT] = '0;

  // Interrupt levels only count above the processor priority
  genvar g;
  for (g = 4; g <= 7; g++) begin : g_hi
    assign lvl[SRC_SW7 + 2 * (7 - g)] =
      software_interrupt_request_level_i[g] && (3'(g) > cur_pri);
    assign lvl[SRC_SW7 + 2 * (7 - g) + 1] =
      bus_request_level_i[g] && (3'(g) > cur_pri);
  end
  for (g = 1; g <= 3; g++) begin : g_lo
    assign lvl[SRC_SW3 + 3 - g] =
      software_interrupt_request_level_i[g] && (3'(g) > cur_pri);
  end

  // Non-aborting sources wait for the instruction to finish
  assign acc = ((pend_reg & EVENT_MASK) | lvl)
               & (ABORT_MASK | {NUM_SRC{instr_boundary_i}});
  assign arb.req = acc;
  wire take = (state_reg == ST_IDLE) && arb.any;
  assign clr = take ? pick_hot : '0;
  // A new event in the clearing cycle stays pending
  assign pend_next = ((pend_reg & ~clr) | ev_set) & EVENT_MASK;

  wire [SRC_W-1:0] pick = arb.idx;
  wire pick_special = (pick == SRC_CONSOLE) || (pick == SRC_FPPX);
  wire pick_br = (pick >= SRC_BR7) && (pick <= SRC_BR4) && pick[0];
  wire pick_sw = (pick >= SRC_SW3) ||
                 ((pick >= SRC_SW7) && (pick < SRC_BR4) && !pick[0]);
  wire [SRC_W-1:0] pick_off = pick - SRC_SW7;
  wire [2:0] pick_lvl = (pick >= SRC_SW3) ? 3'(SRC_SW_TOP - pick)
                                          : PRI_TOP - pick_off[3:1];
  wire [7:0] lvl_hot = 8'h01 << pick_lvl;
  wire [15:0] pick_vec = pick_br ? bus_vector_i : xtp_vector(pick);
  wire [15:0] sel_sp = fatal_reg ? FATAL_SP : stack_pointer_i;

  // ==========================================================
  // Entry sequence: read vector pair, pick stack, push status and counter
  always_comb begin
    state_next = state_reg;
    src_next = src_reg;
    vec_next = vec_reg;
    old_pc_next = old_pc_reg;
    old_ps_next = old_ps_reg;
    new_pc_next = new_pc_reg;
    new_ps_next = new_ps_reg;
    sp_next = sp_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    fatal_next = fatal_reg;
    req_next = req_reg;
    we_next = we_reg;
    mode_next = mode_reg;
    busy_next = busy_reg;
    abort_next = 1'b0;
    halt_next = 1'b0;
    fppg_next = 1'b0;
    load_next = 1'b0;
    bgrant_next = 4'h0;
    swack_next = 7'h00;
    case (state_reg)
      ST_IDLE: begin
        if (take && pick == SRC_CONSOLE) begin
          halt_next = 1'b1;
        end else if (take && pick == SRC_FPPX) begin
          fppg_next = 1'b1;
        end else if (take && !pick_special) begin
          state_next = ST_RD_PC;
          src_next = pick;
          vec_next = pick_vec;
          addr_next = pick_vec;
          req_next = 1'b1;
          we_next = 1'b0;
          busy_next = 1'b1;
          old_pc_next = program_counter_i;
          old_ps_next = processor_status_word_i;
          fatal_next = (pick == SRC_FATAL);
          abort_next = ABORT_MASK[pick];
          bgrant_next = pick_br ? lvl_hot[7:4] : 4'h0;
          swack_next = pick_sw ? lvl_hot[7:1] : 7'h00;
        end
      end
      ST_RD_PC: begin
        if (mem_ack_i) begin
          new_pc_next = mem_rdata_i;
          addr_next = vec_reg + WORD_STEP;
          state_next = ST_RD_PS;
        end
      end
      ST_RD_PS: begin
        if (mem_ack_i) begin
          new_ps_next = mem_rdata_i;
          mode_next = mem_rdata_i[MODE_MSB:MODE_LSB];
          req_next = 1'b0;
          state_next = ST_SEL;
        end
      end
      ST_SEL: begin
        // Core answers the new stack mode with its stack pointer here
        sp_next = sel_sp;
        addr_next = sel_sp - WORD_STEP;
        wdata_next = old_ps_reg;
        req_next = 1'b1;
        we_next = 1'b1;
        state_next = ST_PUSH_PS;
      end
      ST_PUSH_PS: begin
        if (mem_ack_i) begin
          addr_next = sp_reg - PAIR_STEP;
          wdata_next = old_pc_reg;
          state_next = ST_PUSH_PC;
        end
      end
      ST_PUSH_PC: begin
        if (mem_ack_i) begin
          req_next = 1'b0;
          we_next = 1'b0;
          sp_next = sp_reg - PAIR_STEP;
          load_next = 1'b1;
          busy_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        req_next = 1'b0;
        we_next = 1'b0;
        busy_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      pend_reg <= '0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      busy_reg <= 1'b0;
      abort_reg <= 1'b0;
      halt_reg <= 1'b0;
      fppg_reg <= 1'b0;
      load_reg <= 1'b0;
      bgrant_reg <= 4'h0;
      swack_reg <= 7'h00;
      fatal_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pend_reg <= pend_next;
      req_reg <= req_next;
      we_reg <= we_next;
      busy_reg <= busy_next;
      abort_reg <= abort_next;
      halt_reg <= halt_next;
      fppg_reg <= fppg_next;
      load_reg <= load_next;
      bgrant_reg <= bgrant_next;
      swack_reg <= swack_next;
      fatal_reg <= fatal_next;
    end
  end

  // Data path registers, reset to zero so every output is defined
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      {src_reg, vec_reg, old_pc_reg, old_ps_reg} <= '0;
      {new_pc_reg, new_ps_reg, sp_reg, addr_reg, wdata_reg} <= '0;
      mode_reg <= 2'h0;
    end else begin
      {src_reg, vec_reg, old_pc_reg, old_ps_reg} <=
        {src_next, vec_next, old_pc_next, old_ps_next};
      {new_pc_reg, new_ps_reg, sp_reg, addr_reg, wdata_reg} <=
        {new_pc_next, new_ps_next, sp_next, addr_next, wdata_next};
      mode_reg <= mode_next;
    end
  end

  // ==========================================================
  // Bus time-out: counts from master sync, saturates after firing once
  always_ff @(posedge clock_i) begin
    if (rst_i || !tmo_wait) begin
      tmo_cnt_reg <= 16'h0000;
    end else if (tmo_cnt_reg <= TMO_LAST) begin
      tmo_cnt_reg <= tmo_cnt_reg + 16'h0001;
    end
  end

  // ==========================================================
  // Power fail hold: release the supply only after the save window
  wire pf_start = (state_reg == ST_PUSH_PC) && mem_ack_i &&
                  (src_reg == SRC_PWR) && pf_seen_reg;
  always_ff @(posedge clock_i) begin
    if (rst_i || power_restored_i) begin
      pf_seen_reg <= 1'b0;
      pf_run_reg <= 1'b0;
      pf_cnt_reg <= 32'h0;
      release_reg <= 1'b0;
    end else begin
      pf_seen_reg <= pf_seen_reg || power_fail_i;
      pf_run_reg <= pf_run_reg || pf_start;
      if (pf_run_reg && pf_cnt_reg != PF_LAST) begin
        pf_cnt_reg <= pf_cnt_reg + 32'h1;
      end
      release_reg <= release_reg || (pf_run_reg && pf_cnt_reg == PF_LAST);
    end
  end

  assign abort_o = abort_reg;
  assign halt_req_o = halt_reg;
  assign fpp_grant_o = fppg_reg;
  assign bus_grant_o = bgrant_reg;
  assign software_ack_o = swack_reg;
  assign busy_o = busy_reg;
  assign mem_req_o = req_reg;
  assign mem_we_o = we_reg;
  assign mem_addr_o = addr_reg;
  assign mem_wdata_o = wdata_reg;
  assign stack_mode_o = mode_reg;
  assign load_o = load_reg;
  assign program_counter_o = new_pc_reg;
  assign processor_status_word_o = new_ps_reg;
  assign stack_pointer_o = sp_reg;
  assign trap_vector_o = vec_reg;
  assign supply_release_o = release_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_vec_read(logic [15:0] v);
    mem_req_o && !mem_we_o && mem_addr_o == v;
  endsequence
  property p_vector_fixed;
    take && !pick_special && !pick_br |=> s_vec_read(xtp_vector($past(pick)));
  endproperty
  a_vector_fixed: assert property (p_vector_fixed) else $error("bad vector");
  property p_odd_abort;
    take && pick == SRC_ODD |=> abort_o ##0 s_vec_read(VEC_ERR);
  endproperty
  a_odd_abort: assert property (p_odd_abort) else $error("odd no abort");
  property p_power_vec;
    take && pick == SRC_PWR |=> s_vec_read(VEC_PWR);
  endproperty
  a_power_vec: assert property (p_power_vec) else $error("power vector");
  property p_power_hold;
    $rose(supply_release_o) |-> $past(pf_cnt_reg) == PF_LAST;
  endproperty
  a_power_hold: assert property (p_power_hold) else $error("hold short");
  property p_restore;
    power_restored_i |=> pend_reg[SRC_PWR] && !supply_release_o;
  endproperty
  a_restore: assert property (p_restore) else $error("restore lost");
  property p_timeout;
    tmo_wait && tmo_cnt_reg == TMO_LAST |=> pend_reg[SRC_TMO] || busy_o;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no time-out");
  property p_reserved;
    take && pick == SRC_RSV |=> s_vec_read(VEC_RSV) ##0 !abort_o;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved vec");
  sequence s_push_pc;
    mem_we_o && mem_wdata_o == old_pc_reg && mem_addr_o == sp_reg - PAIR_STEP;
  endsequence
  property p_push_order;
    state_reg == ST_PUSH_PS && mem_ack_i |=> s_push_pc;
  endproperty
  a_push_order: assert property (p_push_order) else $error("push order");
  property p_rank;
    arb.any |-> acc[arb.idx] && (acc & (pick_hot - 27'h1)) == '0;
  endproperty
  a_rank: assert property (p_rank) else $error("rank wrong");
  property p_warn_wait;
    take && pick == SRC_WARN |-> instr_boundary_i ##1 !abort_o;
  endproperty
  a_warn_wait: assert property (p_warn_wait) else $error("warn early");
  property p_fatal_sp;
    state_reg == ST_SEL && fatal_reg |=>
      sp_reg == FATAL_SP && mem_addr_o == FATAL_SP - WORD_STEP;
  endproperty
  a_fatal_sp: assert property (p_fatal_sp) else $error("fatal sp");
  property p_level7;
    cur_pri == PRI_TOP |=> bus_grant_o == 4'h0;
  endproperty
  a_level7: assert property (p_level7) else $error("br at level 7");
endmodule

// ### dv/xtp_core_model.sv
/*
  Far side model: memory behind the trap unit's port and the stack pointer.
  Assumes the bench sets slow_i to stretch accesses.
*/
`timescale 1ns/1ns
module xtp_core_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic mem_req_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [1:0] stack_mode_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o,
  output logic [15:0] stack_pointer_o
);
  // ==========
  // Memory
  logic [1:0] wait_reg;
  logic [15:0] word;
  assign word = {~mem_addr_i[7:0], mem_addr_i[7:0]};
  // Data only valid with ack, so show its inverse elsewhere
  assign mem_rdata_o = mem_ack_o ? word : ~word;
  assign stack_pointer_o = {4'h1, stack_mode_i, 10'h000};
  always_ff @(posedge clock_i) begin
    if (rst_i || !mem_req_i || mem_ack_o) begin
      wait_reg <= 2'h0;
      mem_ack_o <= 1'b0;
    end else if (wait_reg >= {slow_i, slow_i}) begin
      mem_ack_o <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule

// ### dv/xtp_trap_unit_bench.sv
/*
  Self-checking bench of the trap unit with a core and memory model.
  Assumes short hold and time-out counts set at the instance.
*/
`timescale 1ns/1ns
module xtp_trap_unit_bench;
  import xtp_pkg::*;
  `define CHK(nm, ex, ac) begin \
    checked++; \
    if ((ac) !== (ex)) begin \
      error_cnt++; \
      $display("MISMATCH %s exp %h got %h", nm, ex, ac); \
    end \
  end
  // ==========
  // Signals
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] ev = 16'h0000;
  logic [7:1] sw_req = 7'h00;
  logic [7:4] br_req = 4'h0;
  logic msync = 1'b0;
  logic ssync = 1'b0;
  logic slow = 1'b0;
  logic bnd = 1'b1;
  logic [7:1] sw_done = 7'h00;
  logic [7:4] br_done = 4'h0;
  logic [15:0] pc_in = 16'h0000;
  logic [15:0] ps_in = 16'h0000;
  logic [31:0] seed = 32'h2573;
  logic [31:0] exp_q[$];
  logic [31:0] exp_e;
  int error_cnt = 0;
  int checked = 0;
  int k;
  logic abort, halt, fppg, busy, req, ack, load, rel, we;
  logic [7:4] bgnt;
  logic [7:1] sack;
  logic [1:0] mode;
  logic [15:0] addr, rdata, sp_in, pc_o, sp_o, vec_o, wdata, ps_o, vp2;
  localparam logic [15:0] VTAB [16] = '{16'h0000, VEC_ERR, VEC_ERR,
    VEC_MMU, VEC_PAR, 16'h0000, VEC_MMU, VEC_ERR, VEC_PWR, VEC_PWR,
    VEC_RSV, VEC_TRACE, VEC_IOT, VEC_EMT, VEC_TRAPI, VEC_FPE};
  always #50 clock_i = ~clock_i;
  xtp_trap_unit #(.PF_HOLD_CYCLES(20), .TIMEOUT_CYCLES(8)) DUT (
    .clock_i(clock_i), .rst_i(rst_i), .console_flag_i(ev[0]),
    .odd_word_access_i(ev[1]), .stack_fatal_i(ev[2]),
    .mmu_violation_i(ev[3]), .parity_error_i(ev[4]),
    .fpp_xfer_req_i(ev[5]), .mmu_trap_i(ev[6]), .stack_warn_i(ev[7]),
    .power_fail_i(ev[8]), .power_restored_i(ev[9]),
    .reserved_opcode_i(ev[10]), .trace_trap_i(ev[11]),
    .io_trap_instruction_i(ev[12]), .emulator_trap_instruction_i(ev[13]),
    .trap_instruction_i(ev[14]), .fpp_exception_i(ev[15]),
    .software_interrupt_request_level_i(sw_req & ~sw_done),
    .bus_request_level_i(br_req & ~br_done), .bus_vector_i(16'h0130),
    .instr_boundary_i(bnd), .master_sync_i(msync), .slave_sync_i(ssync),
    .program_counter_i(pc_in), .processor_status_word_i(ps_in),
    .stack_pointer_i(sp_in), .mem_ack_i(ack), .mem_rdata_i(rdata),
    .abort_o(abort), .halt_req_o(halt), .fpp_grant_o(fppg),
    .bus_grant_o(bgnt), .software_ack_o(sack), .busy_o(busy),
    .mem_req_o(req), .mem_we_o(we), .mem_addr_o(addr),
    .mem_wdata_o(wdata),
    .stack_mode_o(mode), .load_o(load), .program_counter_o(pc_o),
    .processor_status_word_o(ps_o), .stack_pointer_o(sp_o),
    .trap_vector_o(vec_o), .supply_release_o(rel));
  xtp_core_model partner (.clock_i(clock_i), .rst_i(rst_i),
    .slow_i(slow), .mem_req_i(req), .mem_addr_i(addr),
    .stack_mode_i(mode), .mem_ack_o(ack), .mem_rdata_o(rdata),
    .stack_pointer_o(sp_in));
  // ==========
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  // New status comes from vector+2, its mode picks the stack
  function automatic logic [31:0] entry(input logic [15:0] v,
                                        input logic fat);
    logic [15:0] s;
    s = v + 16'h0002;
    entry = {v, fat ? 16'h0000 : {4'h1, ~s[7:6], 10'h000} - 16'h0004};
  endfunction
  task automatic wrap_up();
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || busy !== 1'b0) && n < 300) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    `CHK("entry done", 1'b1, n < 300)
    repeat (3) @(posedge clock_i);
  endtask
  task automatic fire(input logic [15:0] mask, input logic [2:0] fl);
    int i;
    @(posedge clock_i);
    seed = xs(seed);
    pc_in <= seed[15:0];
    ps_in <= {seed[31:24], 3'h0, seed[20:16]};
    slow <= seed[8];
    ev <= mask;
    for (i = 0; i < 16; i++) begin
      if (mask[i] && VTAB[i] != 16'h0000) begin
        exp_q.push_back(entry(VTAB[i], i == 2));
      end
    end
    @(posedge clock_i);
    ev <= 16'h0000;
    #1;
    `CHK("level service", fl[2:1], {halt, fppg})
    @(posedge clock_i);
    #1;
    `CHK("abort", fl[0], abort)
    drain();
  endtask
  // ==========
  // Checking and far side
  always @(posedge clock_i) begin
    if (load === 1'b1) begin
      exp_e = exp_q.size() != 0 ? exp_q.pop_front() : 32'hffffffff;
      `CHK("vector", exp_e[31:16], vec_o)
      `CHK("stack pointer", exp_e[15:0], sp_o)
      `CHK("counter", {~exp_e[23:16], exp_e[23:16]}, pc_o)
      vp2 = exp_e[31:16] + 16'h0002;
      `CHK("status", {~vp2[7:0], vp2[7:0]}, ps_o)
    end
    if (req === 1'b1 && ack === 1'b1 && we === 1'b1) begin
      `CHK("pushed word", addr[1] ? ps_in : pc_in, wdata)
    end
    if (!rst_i) begin
      sw_done <= sw_done | sack;
      br_done <= br_done | bgnt;
    end
  end
  initial begin
    #(100 * 5000);
    error_cnt++;
    wrap_up();
  end
  // ==========
  // Scenarios
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    for (k = 0; k < 16; k++) begin
      fire(16'h0001 << k, {k == 0, k == 5, k inside {[1:4]}});
      if (k == 8) begin
        repeat (14) @(posedge clock_i);
        #1;
        `CHK("supply held", 1'b0, rel)
        repeat (8) @(posedge clock_i);
        #1;
        `CHK("supply released", 1'b1, rel)
      end
      if (k == 9) `CHK("supply restored", 1'b0, rel)
    end
    bnd <= 1'b0;
    fork
      fire(16'h0080, 3'h0);
      begin
        repeat (8) @(posedge clock_i);
        #1;
        `CHK("warn waits", 1'b0, busy)
        @(posedge clock_i);
        bnd <= 1'b1;
      end
    join
    fire(16'h88d2, 3'h1);
    @(posedge clock_i);
    msync <= 1'b1;
    repeat (6) @(posedge clock_i);
    ssync <= 1'b1;
    @(posedge clock_i);
    msync <= 1'b0;
    ssync <= 1'b0;
    repeat (4) @(posedge clock_i);
    exp_q.push_back(entry(VEC_ERR, 1'b0));
    msync <= 1'b1;
    repeat (9) @(posedge clock_i);
    #1;
    `CHK("time-out abort", 1'b1, abort)
    repeat (3) @(posedge clock_i);
    msync <= 1'b0;
    drain();
    ps_in <= 16'h00e0;
    sw_req <= 7'h40;
    br_req <= 4'h8;
    repeat (10) @(posedge clock_i);
    #1;
    `CHK("level 7 held off", 4'h8, br_req & ~br_done)
    exp_q.push_back(entry(VEC_SW, 1'b0));
    exp_q.push_back(entry(VEC_SW, 1'b0));
    exp_q.push_back(entry(16'h0130, 1'b0));
    @(posedge clock_i);
    ps_in <= 16'h0060;
    sw_req <= 7'h18;
    br_req <= 4'h1;
    drain();
    wrap_up();
  end
endmodule
